// *** pkg/hco_cfg.svh ***
// Notes on behaviour
// [RULE_01] Three-bit code picks one of eight frequencies.
// [RULE_02] Crystal divided except low-frequency source selected.
// [RULE_03] Pin drives host clock from reset.
// [RULE_04] Crystal stops while sleeping.
// [RULE_05] Sleep with low-frequency enable gives 32.768 kHz.
// [RULE_06] Idle and receive use the selected code.
// [RULE_07] Sleep without low-frequency enable stops clock.
// [RULE_08] Tail field adds 0, 128, 256, 512 cycles.
// [RULE_09] Pending interrupt keeps clock and crystal running.
// [RULE_10] Control register layout and reset value.
// [RULE_11] Switch and stop only while clock low.
`ifndef HCO_CFG_SVH
`define HCO_CFG_SVH

// ============================================================
// Clock rates and divider counts.
`define HCO_SYS_HZ 125000000
`define HCO_F30M 30000000
`define HCO_F15M 15000000
`define HCO_F10M 10000000
`define HCO_F4M 4000000
`define HCO_F3M 3000000
`define HCO_F2M 2000000
`define HCO_F1M 1000000
`define HCO_HALF_CNT(f) (8'((`HCO_SYS_HZ) / (2 * (f))))

// ============================================================
// Control register address, reset value and fields.
`define HCO_CTRL_ADDR 8'h0a
`define HCO_CTRL_RST 6'h0b
`define HCO_CTRL_RST_CODE 3'h3
`define HCO_CODE_LF 3'h7
`define HCO_TAIL_NONE 2'h0
`define HCO_TAIL_128 10'h080
`define HCO_TAIL_256 10'h100
`define HCO_TAIL_512 10'h200

`endif

// *** pkg/hco_pkg.sv ***
package hco_pkg;

  // Control register contents, bits 5:0.
  typedef struct packed {
    logic [1:0] tail;
    logic lf_en;
    logic [2:0] code;
  } hco_ctrl_s;

  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hco_reg_req_s;

  // Output clock state.
  typedef enum logic [1:0] {
    HCO_ST_RUN,
    HCO_ST_TAIL,
    HCO_ST_LF,
    HCO_ST_OFF
  } hco_state_e;

endpackage

// *** src/hco_div.sv ***
`timescale 1ns/100ps
`include "hco_cfg.svh"

module hco_div (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Control.
  input wire logic run_in,
  input wire logic [7:0] half_cnt_in,
  // Half-period enable pulse.
  output logic tick_out
);
  import hco_pkg::*;

  logic [7:0] cnt_reg;

  // Counts sys clocks and pulses once per half period.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || !run_in) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg >= half_cnt_in - 8'h01) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  assign tick_out = run_in && (cnt_reg >= half_cnt_in - 8'h01);

endmodule // hco_div

// *** src/hco_top.sv ***
`timescale 1ns/100ps
`include "hco_cfg.svh"

module hco_top (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Register port.
  input wire hco_pkg::hco_reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Operating mode and interrupt state.
  input wire logic sleep_cmd_in,
  input wire logic irq_pending_in,
  // Low-frequency sources, asynchronous pins.
  input wire logic rc_osc_in,
  input wire logic ext_32k_in,
  input wire logic lf_ext_sel_in,
  // Host clock pin and status.
  output logic host_clock_pin_out,
  output logic host_clock_pin_oe_out,
  output logic xtal_enable_out,
  output logic sleep_active_out
);
  import hco_pkg::*;

  hco_ctrl_s ctrl_reg;
  hco_state_e state_reg;
  logic [2:0] cur_code_reg;
  logic pin_reg;
  logic [9:0] tail_cnt_reg;
  logic [9:0] tail_target;
  logic [7:0] half_cnt;
  logic [1:0] rc_sync_reg;
  logic [1:0] ext_sync_reg;
  logic lf_prev_reg;
  logic lf_level;
  logic lf_edge;
  logic div_tick;
  logic use_lf;
  logic tick;
  logic sleep_eff;
  logic ctrl_hit;

  // ============================================================
  // Register port.
  assign ctrl_hit = (reg_req_in.addr == `HCO_CTRL_ADDR);

  // Control register write.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      // [RULE_10] Printed reset value.
      ctrl_reg <= `HCO_CTRL_RST;
    end else if (reg_req_in.wr && ctrl_hit) begin
      // [RULE_10] Field layout store.
      ctrl_reg <= reg_req_in.wdata[5:0];
    end
  end

  // Read data, upper two bits and unmapped addresses read zero.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= ctrl_hit ? {2'h0, ctrl_reg} : 8'h00;
    end
  end

  // ============================================================
  // Low-frequency source synchronisers and edge detect.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rc_sync_reg <= 2'h0;
      ext_sync_reg <= 2'h0;
      lf_prev_reg <= 1'h0;
    end else begin
      rc_sync_reg <= {rc_sync_reg[0], rc_osc_in};
      ext_sync_reg <= {ext_sync_reg[0], ext_32k_in};
      lf_prev_reg <= lf_level;
    end
  end

  // [RULE_02] Pick the low-frequency source.
  assign lf_level = lf_ext_sel_in ? ext_sync_reg[1] : rc_sync_reg[1];
  assign lf_edge = lf_level != lf_prev_reg;

  // ============================================================
  // Crystal divider.
  // [RULE_01] Code to half-period count.
  always_comb begin
    case (cur_code_reg)
      3'h0: half_cnt = `HCO_HALF_CNT(`HCO_F30M);
      3'h1: half_cnt = `HCO_HALF_CNT(`HCO_F15M);
      3'h2: half_cnt = `HCO_HALF_CNT(`HCO_F10M);
      3'h3: half_cnt = `HCO_HALF_CNT(`HCO_F4M);
      3'h4: half_cnt = `HCO_HALF_CNT(`HCO_F3M);
      3'h5: half_cnt = `HCO_HALF_CNT(`HCO_F2M);
      default: half_cnt = `HCO_HALF_CNT(`HCO_F1M);
    endcase
  end

  hco_div u_div (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .run_in(xtal_enable_out && !use_lf),
    .half_cnt_in(half_cnt),
    .tick_out(div_tick)
  );

  // [RULE_05] Sleep low-frequency path ignores the code.
  assign use_lf = (state_reg == HCO_ST_LF) || (cur_code_reg == `HCO_CODE_LF);
  assign tick = use_lf ? lf_edge : div_tick;

  // [RULE_09] Pending interrupt holds off sleep.
  assign sleep_eff = sleep_cmd_in && !irq_pending_in;

  // [RULE_08] Tail length decode.
  always_comb begin
    case (ctrl_reg.tail)
      2'h1: tail_target = `HCO_TAIL_128;
      2'h2: tail_target = `HCO_TAIL_256;
      default: tail_target = `HCO_TAIL_512;
    endcase
  end

  // ============================================================
  // Output state machine.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_reg <= HCO_ST_RUN;
    end else begin
      case (state_reg)
        HCO_ST_RUN: begin
          // [RULE_11] Leave only while low.
          if (sleep_eff && !pin_reg) begin
            if (ctrl_reg.lf_en) begin
              state_reg <= HCO_ST_LF;
            end else if (ctrl_reg.tail == `HCO_TAIL_NONE) begin
              // [RULE_11] Stop only when no rise is due, so no runt pulse.
              if (!tick) begin
                state_reg <= HCO_ST_OFF;
              end
            end else begin
              state_reg <= HCO_ST_TAIL;
            end
          end
        end
        HCO_ST_TAIL: begin
          if (!sleep_eff) begin
            state_reg <= HCO_ST_RUN;
          // [RULE_07] Stop after the last tail fall.
          end else if (tick && pin_reg && tail_cnt_reg + 10'h001 == tail_target) begin
            state_reg <= HCO_ST_OFF;
          end
        end
        HCO_ST_LF: begin
          // [RULE_06] Back to selected code on wake.
          if (!sleep_eff && !pin_reg) begin
            state_reg <= HCO_ST_RUN;
          end
        end
        HCO_ST_OFF: begin
          if (!sleep_eff) begin
            state_reg <= HCO_ST_RUN;
          end
        end
        default: state_reg <= HCO_ST_RUN;
      endcase
    end
  end

  // Tail cycle counter, counts falling edges of the pin.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || state_reg != HCO_ST_TAIL) begin
      tail_cnt_reg <= 10'h000;
    end else if (tick && pin_reg) begin
      // [RULE_08] Count tail cycles.
      tail_cnt_reg <= tail_cnt_reg + 10'h001;
    end
  end

  // Active code follows the register only while the pin is low.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cur_code_reg <= `HCO_CTRL_RST_CODE;
    end else if (!pin_reg && (tick || state_reg == HCO_ST_OFF)) begin
      // [RULE_11] Code change at low phase.
      cur_code_reg <= ctrl_reg.code;
    end
  end

  // Pin toggles on each half-period pulse and stays low when stopped.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || state_reg == HCO_ST_OFF) begin
      pin_reg <= 1'h0;
    end else if (tick) begin
      // [RULE_06] Toggle at selected rate.
      pin_reg <= !pin_reg;
    end
  end

  // [RULE_03] Pin driven from reset onward.
  assign host_clock_pin_out = pin_reg;
  assign host_clock_pin_oe_out = 1'h1;
  // [RULE_04] Crystal off in sleep states.
  assign xtal_enable_out = (state_reg == HCO_ST_RUN) || (state_reg == HCO_ST_TAIL);
  assign sleep_active_out = (state_reg == HCO_ST_LF) || (state_reg == HCO_ST_OFF);

  // ============================================================
  // Assertions.
  AST_CTRL_RESET: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_10
    $past(!reset_n_in) |-> ctrl_reg == `HCO_CTRL_RST)
    else $error("Control register reset value wrong.");

  AST_CTRL_WRITE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_10
    reg_req_in.wr && ctrl_hit |=> ctrl_reg == $past(reg_req_in.wdata[5:0]))
    else $error("Control write not stored.");

  AST_OFF_LOW: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_07
    state_reg == HCO_ST_OFF |=> !pin_reg)
    else $error("Pin not low while stopped.");

  AST_LF_XTAL_OFF: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_04
    state_reg == HCO_ST_LF |-> !xtal_enable_out && use_lf)
    else $error("Crystal running in low-frequency sleep.");

  AST_IRQ_WAKE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_09
    irq_pending_in && state_reg == HCO_ST_OFF |=> xtal_enable_out)
    else $error("Interrupt did not restart clock.");

  AST_TAIL_COUNT: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_08
    $past(state_reg) == HCO_ST_TAIL && state_reg == HCO_ST_OFF |-> $past(tail_cnt_reg) + 10'h001 == tail_target)
    else $error("Tail length wrong.");

  AST_PIN_ON_TICK: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_11
    $rose(pin_reg) |-> $past(tick) && $past(state_reg) != HCO_ST_OFF)
    else $error("Pin rose without enable pulse.");

  AST_ENTER_LF: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_05
    state_reg == HCO_ST_RUN && sleep_eff && ctrl_reg.lf_en && !pin_reg |=> state_reg == HCO_ST_LF)
    else $error("Low-frequency sleep not entered.");

  AST_READ_BACK: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_10
    reg_req_in.rd && ctrl_hit |=> reg_rdata_out == {2'h0, $past(ctrl_reg)})
    else $error("Read data mismatch.");

  AST_STOP_CLEAN: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_11
    state_reg == HCO_ST_RUN ##1 state_reg == HCO_ST_OFF |-> !pin_reg)
    else $error("Pin left high when clock stopped.");

  COV_LF: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == HCO_ST_RUN ##1 state_reg == HCO_ST_LF);
  COV_TAIL_OFF: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == HCO_ST_TAIL ##1 state_reg == HCO_ST_OFF);
  COV_WAKE: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == HCO_ST_OFF ##1 state_reg == HCO_ST_RUN);

endmodule // hco_top

// *** tb/hco_mcu_model.sv ***
`timescale 1ns/100ps
// ============================================================
// Host microcontroller that consumes the output clock.
module hco_mcu_model (
  // Clock and observed pin.
  input wire logic sys_clk_in,
  input wire logic host_clock_pin_in,
  // Last high phase length and rising edge count.
  output int hi_len_out,
  output int rise_cnt_out
);
  int cnt = 0;
  logic prev = 1'b0;
  initial begin
    hi_len_out = 0;
    rise_cnt_out = 0;
  end
  // rising edges seen
  // Measures each high phase in system cycles and counts rising edges.
  always @(posedge sys_clk_in) begin
    cnt <= cnt + 1;
    if (host_clock_pin_in !== prev) begin
      if (prev) hi_len_out <= cnt;
      if (host_clock_pin_in) rise_cnt_out <= rise_cnt_out + 1;
      cnt <= 1;
    end
    prev <= host_clock_pin_in;
  end
endmodule // hco_mcu_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
// ============================================================
// Bench for the host clock output block.
module testbench;
  import hco_pkg::*;
  logic sys_clk_in, reset_n_in, sleep_cmd, irq, lf_sel, rc_osc, ext_32k, pin, pin_oe, xtal, sleep_act;
  hco_reg_req_s req;
  logic [7:0] rdata, d;
  int hi_len, rise_cnt, r0, seed;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int fq[7] = '{30000000, 15000000, 10000000, 4000000, 3000000, 2000000, 1000000};
  int tails[4] = '{0, 128, 256, 512};

  hco_top DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .sleep_cmd_in(sleep_cmd), .irq_pending_in(irq), .rc_osc_in(rc_osc), .ext_32k_in(ext_32k),
    .lf_ext_sel_in(lf_sel), .host_clock_pin_out(pin), .host_clock_pin_oe_out(pin_oe),
    .xtal_enable_out(xtal), .sleep_active_out(sleep_act));
  hco_mcu_model mcu (.sys_clk_in(sys_clk_in), .host_clock_pin_in(pin), .hi_len_out(hi_len),
    .rise_cnt_out(rise_cnt));

  // System clock and the two free-running low-frequency sources.
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    rc_osc = 1'b0;
    #3;
    forever #320 rc_osc = ~rc_osc;
  end
  initial begin
    ext_32k = 1'b0;
    #7;
    forever #416 ext_32k = ~ext_32k;
  end

  // Cuts a hang short.
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  // One register write or read; read data is settled one cycle after it is taken.
  task reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    step(1);
    req = '{wr: wr, rd: ~wr, addr: a, wdata: wd};
    step(1);
    req = '0;
    step(1);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    seed = 32'h4bb2;
    reset_n_in = 1'b0;
    req = '0;
    sleep_cmd = 1'b0;
    irq = 1'b0;
    lf_sel = 1'b0;
    repeat (12) @(posedge sys_clk_in);
    #1;
    reset_n_in = 1'b1;
    check({pin_oe, xtal}, 2'b11);
    reg_acc(1'b0, 8'h0a, 8'h00);
    check(rdata, 8'h0b);
    step(100);
    check(hi_len, 125000000 / (2 * fq[3]));
    reg_acc(1'b1, 8'h0b, 8'hff);
    reg_acc(1'b0, 8'h0b, 8'h00);
    check(rdata, 8'h00);
    for (int i = 0; i < 7; i++) begin
      d = 8'($random(seed));
      d[2:0] = i[2:0];
      reg_acc(1'b1, 8'h0a, d);
      reg_acc(1'b0, 8'h0a, 8'h00);
      check(rdata, {2'b00, d[5:0]});
      step(300);
      check(hi_len, 125000000 / (2 * fq[i]));
    end
    for (int s = 0; s < 2; s++) begin
      lf_sel = s[0];
      reg_acc(1'b1, 8'h0a, 8'h07);
      step(400);
      check(hi_len, s ? 52 : 40);
    end
    lf_sel = 1'b0;
    reg_acc(1'b1, 8'h0a, 8'h08);
    step(100);
    sleep_cmd = 1'b1;
    step(400);
    check(hi_len, 40);
    check({xtal, sleep_act}, 2'b01);
    sleep_cmd = 1'b0;
    step(200);
    check(hi_len, 125000000 / (2 * fq[0]));
    for (int t = 0; t < 4; t++) begin
      reg_acc(1'b1, 8'h0a, {2'b00, t[1:0], 4'h0});
      step(20);
      while (pin !== 1'b0) step(1);
      r0 = rise_cnt;
      sleep_cmd = 1'b1;
      step(tails[t] * 4 + 100);
      check(rise_cnt - r0, tails[t]);
      check({pin, xtal, sleep_act}, 3'b001);
      sleep_cmd = 1'b0;
      step(20);
    end
    reg_acc(1'b1, 8'h0a, 8'h00);
    irq = 1'b1;
    r0 = rise_cnt;
    sleep_cmd = 1'b1;
    step(300);
    check({rise_cnt - r0 > 50, xtal}, 2'b11);
    irq = 1'b0;
    step(50);
    check({pin, xtal}, 2'b00);
    sleep_cmd = 1'b0;
    step(20);
    final_report();
  end
endmodule // testbench
